// file: logic/sprcd_pkg.sv
// Constants, types and opcodes for the status, power and reset command decoder
package sprcd_pkg;

	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_RD_SR1  = 8'h05;
	localparam logic [7:0] OP_RD_SR2  = 8'h35;
	localparam logic [7:0] OP_RD_SR3  = 8'h15;
	localparam logic [7:0] OP_RD_SRX  = 8'h65;
	localparam logic [7:0] OP_WR_SR1  = 8'h01;
	localparam logic [7:0] OP_WR_SR2  = 8'h31;
	localparam logic [7:0] OP_WR_SR3  = 8'h11;
	localparam logic [7:0] OP_WR_SRX  = 8'h71;
	localparam logic [7:0] OP_RESUME  = 8'hab;
	localparam logic [7:0] OP_PD_DEEP = 8'hb9;
	localparam logic [7:0] OP_PD_ULTR = 8'h79;
	localparam logic [7:0] OP_RST_EN  = 8'h66;
	localparam logic [7:0] OP_RST_DEV = 8'h99;

	// ==========================================================
	// Fields, counts and reset values
	localparam int              POWER_DOWN_DEPTH_SELECT = 7;
	localparam int              PD_SEL_REG              = 3;
	localparam logic [7:0]      SR_IDX_FIRST            = 8'h01;
	localparam logic [7:0]      SR_IDX_LAST             = 8'h06;
	localparam logic [2:0]      BIT_LAST                = 3'h7;
	localparam logic [1:0]      ADDR_LAST               = 2'h2;
	localparam logic [1:0]      NB_MAX                  = 2'h2;
	localparam logic [47:0]     SR_RST_VAL              = 48'h0;
	// Arbitrary neutral identification value
	localparam logic [7:0]      ID_BYTE                 = 8'h5a;

	// ==========================================================
	// Types
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} sprcd_pins_t;

	typedef enum logic [2:0] {
		PH_CMD,
		PH_ADDR,
		PH_DUMMY,
		PH_WIN,
		PH_OUT,
		PH_END,
		PH_IGNORE
	} sprcd_phase_t;

	typedef struct packed {
		sprcd_phase_t    ph;
		logic [7:0]      op;
		logic [6:0]      rx;
		logic [2:0]      bc;
		logic [1:0]      ac;
		logic [7:0]      idx;
		logic [7:0]      d0;
		logic [7:0]      d1;
		logic [1:0]      nb;
		logic [7:0]      tx;
		logic            so;
		logic            oe;
		logic            deep;
		logic            ultra;
		logic            rst_en;
		logic            rst_pulse;
		logic [5:0][7:0] sr;
	} sprcd_state_t;

	typedef struct packed {
		sprcd_pins_t s1;
		sprcd_pins_t s2;
		sprcd_pins_t s3;
	} sprcd_sync_t;

endpackage

// file: logic/sprcd_pin_sync.sv
// Two-flop pin synchroniser with edge detection for chip select and serial clock
`timescale 1ns/1ns
`default_nettype none
module sprcd_pin_sync
	import sprcd_pkg::*;
(
	input  wire logic        ref_clk_in,  // System clock
	input  wire logic        rst_n_in,    // Synchronous reset, active low
	input  wire sprcd_pins_t raw_in,      // Pins from the link
	output sprcd_pins_t      pins_out,    // Synchronised pins
	output logic             sck_rise_out, // Serial clock rising edge pulse
	output logic             sck_fall_out, // Serial clock falling edge pulse
	output logic             cs_rise_out   // Chip select release pulse
);

	sprcd_sync_t q;
	sprcd_sync_t next_q;

	always_comb begin
		next_q    = q;
		next_q.s1 = raw_in;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			q <= {3{3'h6}};
		end else begin
			q <= next_q;
		end
	end

	assign pins_out     = q.s2;
	assign sck_rise_out = q.s2.sck & ~q.s3.sck;
	assign sck_fall_out = ~q.s2.sck & q.s3.sck;
	assign cs_rise_out  = q.s2.cs_n & ~q.s3.cs_n;

endmodule
`default_nettype wire

// file: logic/sprcd_top.sv
// Serial command decoder for status register, power-down and reset commands
`timescale 1ns/1ns
`default_nettype none
module sprcd_top
	import sprcd_pkg::*;
(
	input  wire logic        ref_clk_in,       // System clock, 250 MHz
	input  wire logic        rst_n_in,         // Synchronous reset, active low
	input  wire logic        cs_n_in,          // Chip select pin, active low
	input  wire logic        sck_in,           // Serial clock pin
	input  wire logic        si_in,            // Serial data in pin
	output logic             so_out,           // Serial data out pin
	output logic             so_oe_out,        // Serial out drive enable
	output logic             deep_pd_out,      // Deep power-down active
	output logic             ultra_pd_out,     // Ultra-deep power-down active
	output logic             soft_reset_out,   // Software reset pulse
	output logic [5:0][7:0]  status_out        // Status registers one to six
);

	// ==========================================================
	// Pin synchronisation
	sprcd_pins_t  raw;
	sprcd_pins_t  ps;
	logic         sck_rise;
	logic         sck_fall;
	logic         cs_rise;

	assign raw = '{cs_n: cs_n_in, sck: sck_in, si: si_in};

	sprcd_pin_sync u_sync (
		.ref_clk_in   (ref_clk_in),
		.rst_n_in     (rst_n_in),
		.raw_in       (raw),
		.pins_out     (ps),
		.sck_rise_out (sck_rise),
		.sck_fall_out (sck_fall),
		.cs_rise_out  (cs_rise)
	);

	// ==========================================================
	// Helpers
	function automatic logic idx_ok(input logic [7:0] idx);
		idx_ok = (idx >= SR_IDX_FIRST) && (idx <= SR_IDX_LAST);
	endfunction

	function automatic logic [7:0] sr_sel(input logic [5:0][7:0] sr, input logic [7:0] idx);
		logic [2:0] k;
		k      = idx[2:0] - 3'h1;
		sr_sel = 8'h00;
		if (idx_ok(idx)) begin
			sr_sel = sr[k];
		end
	endfunction

	sprcd_state_t q;
	sprcd_state_t next_q;
	logic [7:0]   rxb;
	logic         done;
	logic         pd;
	logic [2:0]   widx;

	assign rxb  = {q.rx, ps.si};
	assign done = sck_rise && !ps.cs_n && (q.bc == BIT_LAST);
	assign pd   = q.deep | q.ultra;
	assign widx = q.idx[2:0] - 3'h1;

	// ==========================================================
	// Next state
	always_comb begin
		next_q           = q;
		next_q.rst_pulse = 1'b0;
		if (cs_rise) begin
			if (q.bc == 3'h0) begin
				if (q.ph == PH_WIN && q.nb != 2'h0) begin
					case (q.op)
						OP_WR_SR1: begin
							next_q.sr[0] = q.d0;
							if (q.nb == NB_MAX) begin
								next_q.sr[1] = q.d1;
							end
						end
						OP_WR_SR2: next_q.sr[1] = q.d0;
						OP_WR_SR3: next_q.sr[2] = q.d0;
						OP_WR_SRX: begin
							if (idx_ok(q.idx)) begin
								next_q.sr[widx] = q.d0;
							end
						end
						default: ;
					endcase
				end
				if (q.ph == PH_END) begin
					case (q.op)
						OP_PD_DEEP: begin
							if (q.sr[PD_SEL_REG][POWER_DOWN_DEPTH_SELECT]) begin
								next_q.deep = 1'b1;
							end else begin
								next_q.ultra = 1'b1;
							end
						end
						OP_PD_ULTR: next_q.ultra = 1'b1;
						OP_RST_EN: next_q.rst_en = 1'b1;
						OP_RST_DEV: begin
							if (q.rst_en) begin
								next_q.sr        = SR_RST_VAL;
								next_q.deep      = 1'b0;
								next_q.ultra     = 1'b0;
								next_q.rst_en    = 1'b0;
								next_q.rst_pulse = 1'b1;
							end
						end
						default: ;
					endcase
				end
				if (q.op == OP_RESUME && q.ph != PH_CMD && q.ph != PH_IGNORE) begin
					next_q.deep  = 1'b0;
					next_q.ultra = 1'b0;
				end
			end
			next_q.ph = PH_CMD;
			next_q.bc = 3'h0;
			next_q.ac = 2'h0;
			next_q.nb = 2'h0;
			next_q.oe = 1'b0;
			next_q.so = 1'b0;
		end else if (!ps.cs_n) begin
			if (sck_rise) begin
				next_q.rx = rxb[6:0];
				next_q.bc = q.bc + 3'h1;
			end
			if (done) begin
				case (q.ph)
					PH_CMD: begin
						next_q.op     = rxb;
						next_q.rst_en = q.rst_en & (rxb == OP_RST_DEV);
						next_q.ph     = PH_IGNORE;
						if (!pd || rxb == OP_RESUME) begin
							case (rxb)
								OP_RD_SR1: begin
									next_q.tx = q.sr[0];
									next_q.ph = PH_OUT;
								end
								OP_RD_SR2: begin
									next_q.tx = q.sr[1];
									next_q.ph = PH_OUT;
								end
								OP_RD_SR3: begin
									next_q.tx = q.sr[2];
									next_q.ph = PH_OUT;
								end
								OP_WR_SR1, OP_WR_SR2, OP_WR_SR3: next_q.ph = PH_WIN;
								OP_RD_SRX, OP_WR_SRX, OP_RESUME: next_q.ph = PH_ADDR;
								OP_PD_DEEP, OP_PD_ULTR, OP_RST_EN, OP_RST_DEV: next_q.ph = PH_END;
								default: ;
							endcase
						end
					end
					PH_ADDR: begin
						next_q.ac = q.ac + 2'h1;
						if (q.op == OP_RESUME) begin
							if (q.ac == ADDR_LAST) begin
								next_q.tx = ID_BYTE;
								next_q.ph = PH_OUT;
							end
						end else begin
							next_q.idx = rxb;
							next_q.ph  = (q.op == OP_RD_SRX) ? PH_DUMMY : PH_WIN;
						end
					end
					PH_DUMMY: begin
						next_q.tx = sr_sel(q.sr, q.idx);
						next_q.ph = PH_OUT;
					end
					PH_WIN: begin
						if (q.nb == 2'h0) begin
							next_q.d0 = rxb;
						end else if (q.nb == 2'h1) begin
							next_q.d1 = rxb;
						end
						next_q.nb = (q.nb == NB_MAX) ? NB_MAX : q.nb + 2'h1;
					end
					PH_OUT: begin
						case (q.op)
							OP_RD_SRX: begin
								next_q.idx = q.idx + 8'h01;
								next_q.tx  = sr_sel(q.sr, q.idx + 8'h01);
							end
							OP_RESUME: next_q.tx = ID_BYTE;
							OP_RD_SR1: next_q.tx = q.sr[0];
							OP_RD_SR2: next_q.tx = q.sr[1];
							default: next_q.tx = q.sr[2];
						endcase
					end
					PH_END: next_q.ph = PH_IGNORE;
					default: ;
				endcase
			end
			if (sck_fall && q.ph == PH_OUT) begin
				next_q.so = q.tx[7];
				next_q.tx = {q.tx[6:0], 1'b0};
				next_q.oe = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			q    <= '0;
			q.ph <= PH_CMD;
			q.sr <= SR_RST_VAL;
		end else begin
			q <= next_q;
		end
	end

	assign so_out         = q.so;
	assign so_oe_out      = q.oe;
	assign deep_pd_out    = q.deep;
	assign ultra_pd_out   = q.ultra;
	assign soft_reset_out = q.rst_pulse;
	assign status_out     = q.sr;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_rd_sr1;
		done && q.ph == PH_CMD && rxb == OP_RD_SR1 && !pd |=> q.ph == PH_OUT && q.tx == q.sr[0];
	endproperty
	a_rd_sr1: assert property (p_rd_sr1) else $error("sr1 read not loaded");

	property p_rd_sr2;
		done && q.ph == PH_CMD && rxb == OP_RD_SR2 && !pd |=> q.ph == PH_OUT && q.tx == q.sr[1];
	endproperty
	a_rd_sr2: assert property (p_rd_sr2) else $error("sr2 read not loaded");

	property p_rd_sr3;
		done && q.ph == PH_CMD && rxb == OP_RD_SR3 && !pd |=> q.ph == PH_OUT && q.tx == q.sr[2];
	endproperty
	a_rd_sr3: assert property (p_rd_sr3) else $error("sr3 read not loaded");

	property p_rd_srx;
		done && q.ph == PH_DUMMY |=> q.ph == PH_OUT && q.tx == sr_sel($past(q.sr), $past(q.idx));
	endproperty
	a_rd_srx: assert property (p_rd_srx) else $error("selected read wrong");

	property p_wr_srx;
		cs_rise && q.bc == 3'h0 && q.ph == PH_WIN && q.op == OP_WR_SRX && q.nb != 2'h0
			&& idx_ok(q.idx) |=> q.sr[$past(widx)] == $past(q.d0);
	endproperty
	a_wr_srx: assert property (p_wr_srx) else $error("selected write lost");

	property p_resume_id;
		done && q.ph == PH_ADDR && q.op == OP_RESUME && q.ac == ADDR_LAST
			|=> q.tx == ID_BYTE && q.ph == PH_OUT;
	endproperty
	a_resume_id: assert property (p_resume_id) else $error("id byte not loaded");

	property p_auto_inc;
		done && q.ph == PH_OUT && q.op == OP_RD_SRX |=> q.idx == $past(q.idx) + 8'h01;
	endproperty
	a_auto_inc: assert property (p_auto_inc) else $error("select not incremented");

	property p_pd_depth;
		cs_rise && q.bc == 3'h0 && q.ph == PH_END && q.op == OP_PD_DEEP
			|=> q.deep == $past(q.sr[PD_SEL_REG][POWER_DOWN_DEPTH_SELECT])
			&& q.ultra == !$past(q.sr[PD_SEL_REG][POWER_DOWN_DEPTH_SELECT]);
	endproperty
	a_pd_depth: assert property (p_pd_depth) else $error("wrong power-down depth");

	property p_rst_seq;
		$rose(q.rst_pulse) |-> $past(q.rst_en) && q.sr == SR_RST_VAL ##1 !q.rst_pulse;
	endproperty
	a_rst_seq: assert property (p_rst_seq) else $error("reset without enable");

	property p_legacy;
		cs_rise && q.bc == 3'h0 && q.ph == PH_WIN && q.op == OP_WR_SR1 && q.nb == NB_MAX
			|=> q.sr[0] == $past(q.d0) && q.sr[1] == $past(q.d1);
	endproperty
	a_legacy: assert property (p_legacy) else $error("two-byte write lost");

	property p_cut_short;
		cs_rise && q.bc != 3'h0 |=> $stable(q.sr) && $stable(q.deep) && $stable(q.ultra);
	endproperty
	a_cut_short: assert property (p_cut_short) else $error("partial write took effect");

	c_rd_sr1: cover property (done && q.ph == PH_CMD && rxb == OP_RD_SR1);
	c_multi:  cover property (done && q.ph == PH_OUT && q.op == OP_RD_SRX && q.idx == SR_IDX_LAST);
	c_deep:   cover property ($rose(q.deep));
	c_reset:  cover property (q.rst_pulse);

endmodule
`default_nettype wire

// file: sim/sprcd_host_model.sv
// SPI host model driving the decoder's link pins in mode 0
`timescale 1ns/1ns
`default_nettype none
module sprcd_host_model (
	input  wire logic clk_in,   // Bench clock, frames start after its edge
	input  wire logic so_in,    // Serial data from device
	output var logic  cs_n_out, // Chip select, active low
	output var logic  sck_out,  // Serial clock, idle low between frames
	output var logic  si_out    // Serial data to device
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
	end

	// ==========================================================
	// One frame, MSB first, so sampled on each rising edge
	task automatic xfer(input int nbits, input logic [79:0] tx, output logic [79:0] rx);
		rx = '0;
		@(posedge clk_in);
		#1 cs_n_out = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			si_out = tx[i];
			#40 sck_out = 1'b1;
			rx = {rx[78:0], so_in};
			#40 sck_out = 1'b0;
		end
		#40 cs_n_out = 1'b1;
		// Released line must not keep its last level
		si_out = ~si_out;
		#80;
	endtask
endmodule
`default_nettype wire

// file: sim/sprcd_top_tb.sv
// Self-checking bench for the status, power and reset command decoder
`timescale 1ns/1ns
`default_nettype none
module sprcd_top_tb;
	import sprcd_pkg::*;

	logic            ref_clk;
	logic            rst_n;
	logic            cs_n, sck, si, so, so_oe, deep_pd, ultra_pd, soft_reset;
	logic            so_line;
	logic [5:0][7:0] status;
	logic [79:0]     rx;
	logic [7:0]      sr_exp [1:6];
	int              error_cnt;
	int              checked;
	int              rst_seen;

	always #2 ref_clk = ~ref_clk;

	// Undriven output line shows the inverse level to the host
	assign so_line = so_oe ? so : ~so;

	always @(posedge ref_clk) begin
		if (soft_reset === 1'b1) begin
			rst_seen++;
		end
	end

	sprcd_top dut_u (
		.ref_clk_in(ref_clk), .rst_n_in(rst_n), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
		.so_out(so), .so_oe_out(so_oe), .deep_pd_out(deep_pd), .ultra_pd_out(ultra_pd),
		.soft_reset_out(soft_reset), .status_out(status)
	);

	sprcd_host_model host_u (
		.clk_in(ref_clk), .so_in(so_line), .cs_n_out(cs_n), .sck_out(sck), .si_out(si)
	);

	// ==========================================================
	// Shared helpers
	task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic check_sr();
		for (int i = 1; i <= 6; i++) begin
			check(48'(status[i - 1]), 48'(sr_exp[i]), "status register");
		end
	endtask

	task automatic send(input int nbits, input logic [79:0] tx);
		host_u.xfer(nbits, tx, rx);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_idle();
		check(48'({so_oe, deep_pd, ultra_pd, soft_reset}), 48'h0, "idle outputs");
		check_sr();
	endtask

	task automatic t_direct();
		logic [7:0] wop [3] = '{OP_WR_SR1, OP_WR_SR2, OP_WR_SR3};
		logic [7:0] rop [3] = '{OP_RD_SR1, OP_RD_SR2, OP_RD_SR3};
		logic [7:0] v;
		for (int i = 0; i < 3; i++) begin
			v = 8'h5c ^ 8'(i * 8'h21);
			send(16, {64'h0, wop[i], v});
			sr_exp[i + 1] = v;
			check_sr();
			send(24, {56'h0, rop[i], 16'h0});
			check(48'(rx[15:0]), 48'({v, v}), "direct read");
			check(48'(so_oe), 48'h0, "drive not released");
		end
	endtask

	task automatic t_legacy();
		send(24, {56'h0, OP_WR_SR1, 8'hc3, 8'h3c});
		sr_exp[1] = 8'hc3;
		sr_exp[2] = 8'h3c;
		check_sr();
	endtask

	task automatic t_srx();
		logic [7:0] v;
		for (logic [7:0] s = 8'h04; s <= SR_IDX_LAST; s++) begin
			v = 8'h90 | s;
			send(24, {56'h0, OP_WR_SRX, s, v});
			sr_exp[s] = v;
			send(32, {48'h0, OP_RD_SRX, s, 16'h0});
			check(48'(rx[7:0]), 48'(v), "selected read");
		end
		send(24, {56'h0, OP_WR_SRX, 8'h07, 8'hff});
		check_sr();
	endtask

	task automatic t_multi();
		send(72, {8'h0, OP_RD_SRX, SR_IDX_FIRST, 8'h00, 48'h0});
		check(rx[47:0], {sr_exp[1], sr_exp[2], sr_exp[3], sr_exp[4], sr_exp[5], sr_exp[6]},
			"multi read");
	endtask

	task automatic t_partial();
		send(12, {68'h0, OP_WR_SR2, 4'ha});
		send(15, {65'h0, OP_WR_SR3, 7'h55});
		send(8, {72'h0, OP_WR_SR1});
		check_sr();
	endtask

	task automatic t_power();
		send(8, {72'h0, OP_PD_DEEP});
		check(48'({deep_pd, ultra_pd}), 48'h2, "deep entry");
		send(16, {64'h0, OP_WR_SR2, 8'h11});
		check_sr();
		send(40, {40'h0, OP_RESUME, 24'h0, 8'h0});
		check(48'(rx[7:0]), 48'(ID_BYTE), "wake id");
		check(48'({deep_pd, ultra_pd}), 48'h0, "wake");
		send(24, {56'h0, OP_WR_SRX, 8'h04, 8'h14});
		sr_exp[4] = 8'h14;
		send(8, {72'h0, OP_PD_DEEP});
		check(48'({deep_pd, ultra_pd}), 48'h1, "ultra entry");
		send(8, {72'h0, OP_RESUME});
		check(48'({deep_pd, ultra_pd}), 48'h0, "ultra wake");
		send(8, {72'h0, OP_PD_ULTR});
		check(48'({deep_pd, ultra_pd}), 48'h1, "direct ultra entry");
		send(8, {72'h0, OP_RESUME});
		check(48'({deep_pd, ultra_pd}), 48'h0, "direct ultra wake");
	endtask

	task automatic t_soft();
		rst_seen = 0;
		send(8, {72'h0, OP_RST_EN});
		send(16, {64'h0, OP_RD_SR1, 8'h0});
		send(8, {72'h0, OP_RST_DEV});
		check(48'(rst_seen), 48'h0, "broken reset pair");
		check_sr();
		send(8, {72'h0, OP_RST_EN});
		send(8, {72'h0, OP_RST_DEV});
		check(48'(rst_seen), 48'h1, "reset pulse");
		for (int i = 1; i <= 6; i++) begin
			sr_exp[i] = 8'h00;
		end
		check_sr();
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		error_cnt = 0;
		checked = 0;
		rst_seen = 0;
		for (int i = 1; i <= 6; i++) begin
			sr_exp[i] = 8'h00;
		end
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		t_idle();
		t_direct();
		t_legacy();
		t_srx();
		t_multi();
		t_partial();
		t_power();
		t_soft();
		give_verdict();
	end

	initial begin
		#120000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
